// >>> logic/txsac_cfg.svh
// offsets, field positions, reset values and threshold byte counts of the tx status block
`ifndef TXSAC_CFG_SVH
`define TXSAC_CFG_SVH
`define TXSAC_OFF_STATUS   8'h28
`define TXSAC_OFF_NAR      8'h30
`define TXSAC_OFF_MASK     8'h38
`define TXSAC_OFF_TXCTL    8'h3C
`define TXSAC_BIT_TCI      0
`define TXSAC_BIT_TPS      1
`define TXSAC_BIT_TDU      2
`define TXSAC_BIT_TJT      3
`define TXSAC_BIT_TO       14
`define TXSAC_BIT_IC       31
`define TXSAC_BIT_SF       21
`define TXSAC_BIT_SQE      19
`define TXSAC_BIT_TR_HI    15
`define TXSAC_BIT_TR_LO    14
`define TXSAC_BIT_RUN      13
`define TXSAC_SQE_RST      1'h1
`define TXSAC_TR_RST       2'h0
`define TXSAC_RESP_OKAY    2'h0
`define TXSAC_RESP_SLVERR  2'h2
`define TXSAC_THR100_0     12'h080
`define TXSAC_THR100_1     12'h100
`define TXSAC_THR100_2     12'h200
`define TXSAC_THR100_3     12'h400
`define TXSAC_THR10_0      12'h048
`define TXSAC_THR10_1      12'h060
`define TXSAC_THR10_2      12'h080
`define TXSAC_THR10_3      12'h0A0
`endif

// >>> logic/txsac_pkg.sv
// types of the tx status and access control block
package txsac_pkg;
	typedef enum logic [1:0] {
		TXSAC_STOP,
		TXSAC_RUN,
		TXSAC_SUSP
	} txsac_state_t;

	// events coming from the descriptor engine and mac
	typedef struct packed {
		logic jabber_expired;
		logic desc_missing;
		logic frame_done;
		logic first_desc_ic;
		logic poll_demand;
		logic auto_poll_en;
	} txsac_evt_t;

	// controls seen by the transmit datapath
	typedef struct packed {
		logic        fetch_en;
		logic        start_tx;
		logic        sqe_test_en;
		logic        jabber_flag_in_desc;
		logic [11:0] threshold_bytes;
		logic [2:0]  tx_state_code;
	} txsac_ctl_t;

	typedef struct packed {
		logic         aw_got;
		logic         w_got;
		logic [7:0]   awaddr;
		logic [31:0]  wdata;
		logic [3:0]   wstrb;
		logic         bvalid;
		logic [1:0]   bresp;
		logic         rvalid;
		logic [31:0]  rdata;
		logic [1:0]   rresp;
		logic [3:0]   status;
		logic [3:0]   mask;
		logic         store_forward_en;
		logic         sqe_disable;
		logic [1:0]   tx_threshold;
		logic         tx_run_control;
		txsac_state_t state;
		logic         jabber_desc;
	} txsac_regs_t;
endpackage

// >>> logic/txsac_top.sv
// tx status flags, network access controls and axi4-lite slave
//
// Overview of operation
// [R01] jabber expiry: flag bit 3, stop, desc bit 14; stops from run only, in suspend flag and desc bit set but state kept
// [R02] missing descriptor: flag bit 2, suspend
// [R03] host restarts via ownership then poll demand
// [R04] stopped flag bit 1 while in stop
// [R05] done flag bit 0 only with ic set
// [R06] flags latch, cleared by writing one
// [R07] store-and-forward bit 21 waits whole frame
// [R08] bit 19 disables heartbeat test, resets one
// [R09] threshold bits 15:14 select start level
// [R10] run bit 13 resets zero, holds stop
// [R11] host changes controls only while stopped; the code accepts NAR writes in any state
// [R12] writing run one starts descriptor fetching
// [R13] start at threshold or complete frame
`timescale 1ns/1ps
`include "txsac_cfg.svh"

module txsac_top (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire txsac_pkg::txsac_evt_t evt,
	input  wire logic              speed_100,
	input  wire logic [11:0]       fifo_bytes,
	input  wire logic              fifo_frame_whole,
	output txsac_pkg::txsac_ctl_t  ctl,
	output logic                   irq
);

	txsac_pkg::txsac_regs_t r_ff;
	txsac_pkg::txsac_regs_t nxt_r;

	// threshold byte count for a code and line speed
	function automatic logic [11:0] thr_bytes(input logic [1:0] code, input logic fast);
		logic [11:0] v;
		v = 12'h000;
		case (code)
			2'h0: v = fast ? `TXSAC_THR100_0 : `TXSAC_THR10_0;
			2'h1: v = fast ? `TXSAC_THR100_1 : `TXSAC_THR10_1;
			2'h2: v = fast ? `TXSAC_THR100_2 : `TXSAC_THR10_2;
			default: v = fast ? `TXSAC_THR100_3 : `TXSAC_THR10_3;
		endcase
		return v;
	endfunction

	logic wr_fire;
	logic rd_fire;
	logic [31:0] nar_word;
	logic [31:0] txctl_word;

	// ------------------------------------------------------------
	// bus handshakes
	// ------------------------------------------------------------
	assign s_axi_awready = !r_ff.aw_got && !r_ff.bvalid;
	assign s_axi_wready  = !r_ff.w_got && !r_ff.bvalid;
	assign s_axi_arready = !r_ff.rvalid;
	assign wr_fire = (r_ff.aw_got || s_axi_awvalid) && (r_ff.w_got || s_axi_wvalid)
		&& !r_ff.bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	// register read images
	always_comb begin
		nar_word = 32'h0000_0000;
		nar_word[`TXSAC_BIT_SF] = r_ff.store_forward_en;
		nar_word[`TXSAC_BIT_SQE] = r_ff.sqe_disable;
		nar_word[`TXSAC_BIT_TR_HI:`TXSAC_BIT_TR_LO] = r_ff.tx_threshold;
		nar_word[`TXSAC_BIT_RUN] = r_ff.tx_run_control;
		txctl_word = 32'h0000_0000;
		txctl_word[2:0] = ctl.tx_state_code;
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [7:0]  wa;
		logic [31:0] wd;
		logic [3:0]  clr;
		logic [3:0]  set;
		logic        run_rise;
		wa = 8'h00;
		wd = 32'h0000_0000;
		clr = 4'h0;
		set = 4'h0;
		run_rise = 1'b0;
		nxt_r = r_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_r.aw_got = 1'b1;
			nxt_r.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_r.w_got = 1'b1;
			nxt_r.wdata = s_axi_wdata;
			nxt_r.wstrb = s_axi_wstrb;
		end
		wa = r_ff.aw_got ? r_ff.awaddr : s_axi_awaddr;
		wd = r_ff.w_got ? r_ff.wdata : s_axi_wdata;
		if (wr_fire) begin
			nxt_r.aw_got = 1'b0;
			nxt_r.w_got = 1'b0;
			nxt_r.bvalid = 1'b1;
			nxt_r.bresp = `TXSAC_RESP_OKAY;
			case ({wa[7:2], 2'h0})
				// [R06] write one clears
				`TXSAC_OFF_STATUS: clr = wd[3:0];
				`TXSAC_OFF_MASK: nxt_r.mask = wd[3:0];
				`TXSAC_OFF_NAR: begin
					nxt_r.store_forward_en = wd[`TXSAC_BIT_SF];
					nxt_r.sqe_disable = wd[`TXSAC_BIT_SQE];
					nxt_r.tx_threshold = wd[`TXSAC_BIT_TR_HI:`TXSAC_BIT_TR_LO];
					nxt_r.tx_run_control = wd[`TXSAC_BIT_RUN];
					// [R12] run written one while stopped
					run_rise = wd[`TXSAC_BIT_RUN] && r_ff.state == txsac_pkg::TXSAC_STOP;
				end
				`TXSAC_OFF_TXCTL: ;
				default: nxt_r.bresp = `TXSAC_RESP_SLVERR;
			endcase
		end
		if (r_ff.bvalid && s_axi_bready)
			nxt_r.bvalid = 1'b0;
		if (rd_fire) begin
			nxt_r.rvalid = 1'b1;
			nxt_r.rresp = `TXSAC_RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'h0})
				`TXSAC_OFF_STATUS: nxt_r.rdata = {28'h0000000, r_ff.status};
				`TXSAC_OFF_MASK: nxt_r.rdata = {28'h0000000, r_ff.mask};
				`TXSAC_OFF_NAR: nxt_r.rdata = nar_word;
				`TXSAC_OFF_TXCTL: nxt_r.rdata = txctl_word;
				default: begin
					nxt_r.rdata = 32'h0000_0000;
					nxt_r.rresp = `TXSAC_RESP_SLVERR;
				end
			endcase
		end else if (r_ff.rvalid && s_axi_rready)
			nxt_r.rvalid = 1'b0;

		// transmit process state machine
		case (r_ff.state)
			txsac_pkg::TXSAC_STOP: begin
				// [R12] leave stop on run
				if (run_rise)
					nxt_r.state = txsac_pkg::TXSAC_RUN;
			end
			txsac_pkg::TXSAC_RUN: begin
				// [R01] jabber stops the process
				if (evt.jabber_expired)
					nxt_r.state = txsac_pkg::TXSAC_STOP;
				// [R02] missing descriptor suspends
				else if (evt.desc_missing)
					nxt_r.state = txsac_pkg::TXSAC_SUSP;
			end
			txsac_pkg::TXSAC_SUSP: begin
				// [R03] resume on poll or auto poll
				if (evt.poll_demand || evt.auto_poll_en)
					nxt_r.state = txsac_pkg::TXSAC_RUN;
			end
			default: nxt_r.state = txsac_pkg::TXSAC_STOP;
		endcase
		// [R10] run bit low forces stop
		if (!nxt_r.tx_run_control)
			nxt_r.state = txsac_pkg::TXSAC_STOP;

		// [R01] jabber flag and descriptor bit
		set[`TXSAC_BIT_TJT] = evt.jabber_expired && r_ff.state != txsac_pkg::TXSAC_STOP;
		if (set[`TXSAC_BIT_TJT])
			nxt_r.jabber_desc = 1'b1;
		else if (run_rise)
			nxt_r.jabber_desc = 1'b0;
		// [R02] descriptor missing flag
		set[`TXSAC_BIT_TDU] = evt.desc_missing && r_ff.state == txsac_pkg::TXSAC_RUN;
		// [R04] stopped flag while in stop
		set[`TXSAC_BIT_TPS] = r_ff.state == txsac_pkg::TXSAC_STOP;
		// [R05] done only with ic request
		set[`TXSAC_BIT_TCI] = evt.frame_done && evt.first_desc_ic;
		// [R06] set wins over clear
		nxt_r.status = (r_ff.status & ~clr) | set;

		if (!aresetn) begin
			nxt_r = '0;
			nxt_r.rdata = 32'h0000_0000;
			// [R08] heartbeat disable resets one
			nxt_r.sqe_disable = `TXSAC_SQE_RST;
			nxt_r.tx_threshold = `TXSAC_TR_RST;
			nxt_r.state = txsac_pkg::TXSAC_STOP;
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		r_ff <= nxt_r;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign s_axi_bvalid = r_ff.bvalid;
	assign s_axi_bresp  = r_ff.bresp;
	assign s_axi_rvalid = r_ff.rvalid;
	assign s_axi_rdata  = r_ff.rdata;
	assign s_axi_rresp  = r_ff.rresp;
	assign irq = |(r_ff.status & r_ff.mask); // level interrupt

	// datapath controls
	always_comb begin
		ctl.fetch_en = r_ff.state == txsac_pkg::TXSAC_RUN;
		// [R08] heartbeat test enable
		ctl.sqe_test_en = !r_ff.sqe_disable;
		// [R09] threshold selection
		ctl.threshold_bytes = thr_bytes(r_ff.tx_threshold, speed_100);
		// [R07] whole frame in store-forward
		// [R13] threshold or whole frame
		ctl.start_tx = ctl.fetch_en && (fifo_frame_whole
			|| (!r_ff.store_forward_en && fifo_bytes >= ctl.threshold_bytes));
		ctl.jabber_flag_in_desc = r_ff.jabber_desc;
		case (r_ff.state)
			txsac_pkg::TXSAC_RUN: ctl.tx_state_code = 3'h2;
			txsac_pkg::TXSAC_SUSP: ctl.tx_state_code = 3'h6;
			default: ctl.tx_state_code = 3'h0;
		endcase
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_jab;
		evt.jabber_expired && r_ff.state == txsac_pkg::TXSAC_RUN;
	endsequence
	sequence s_jab_after;
		r_ff.status[`TXSAC_BIT_TJT] && r_ff.state == txsac_pkg::TXSAC_STOP && r_ff.jabber_desc;
	endsequence
	a_jabber_stop: assert property (@(posedge aclk) disable iff (!aresetn) // [R01]
		s_jab |=> s_jab_after) else $error("jabber did not stop and flag");
	a_desc_missing: assert property (@(posedge aclk) disable iff (!aresetn) // [R02]
		evt.desc_missing && r_ff.state == txsac_pkg::TXSAC_RUN && !evt.jabber_expired
		&& r_ff.tx_run_control && !wr_fire |=> r_ff.status[`TXSAC_BIT_TDU]
		&& r_ff.state == txsac_pkg::TXSAC_SUSP) else $error("missing descriptor not flagged");
	a_stop_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [R04]
		r_ff.state == txsac_pkg::TXSAC_STOP |=> r_ff.status[`TXSAC_BIT_TPS])
		else $error("stopped flag absent");
	a_done_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [R05]
		!r_ff.status[`TXSAC_BIT_TCI] && !(evt.frame_done && evt.first_desc_ic)
		|=> !r_ff.status[`TXSAC_BIT_TCI]) else $error("done flag without ic");
	a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // [R06]
		r_ff.status[`TXSAC_BIT_TJT] && !wr_fire |=> r_ff.status[`TXSAC_BIT_TJT])
		else $error("flag dropped without clear");
	a_store_fwd: assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
		r_ff.store_forward_en && !fifo_frame_whole |-> !ctl.start_tx)
		else $error("started before whole frame");
	a_sqe_test: assert property (@(posedge aclk) disable iff (!aresetn) // [R08]
		ctl.sqe_test_en == !r_ff.sqe_disable && ($past(aresetn) || r_ff.sqe_disable))
		else $error("heartbeat enable wrong");
	a_thr_base: assert property (@(posedge aclk) disable iff (!aresetn) // [R09]
		r_ff.tx_threshold == 2'h0 |-> ctl.threshold_bytes == (speed_100 ? 12'h080 : 12'h048))
		else $error("threshold wrong");
	a_run_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
		!r_ff.tx_run_control |-> r_ff.state == txsac_pkg::TXSAC_STOP)
		else $error("running without run bit");
	a_run_start: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
		$rose(r_ff.tx_run_control) && $past(r_ff.state) == txsac_pkg::TXSAC_STOP
		|-> r_ff.state == txsac_pkg::TXSAC_RUN && ctl.fetch_en) else $error("run did not start");
	a_thr_start: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
		ctl.fetch_en && !r_ff.store_forward_en && fifo_bytes >= ctl.threshold_bytes
		|-> ctl.start_tx) else $error("threshold reached but no start");

endmodule

// >>> tb/txsac_engine_model.sv
// behavioural descriptor engine and mac that raise transmit events
`timescale 1ns/1ps

module txsac_engine_model (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire txsac_pkg::txsac_ctl_t ctl,
	input  wire logic [3:0]            req,
	input  wire logic                  req_ic,
	input  wire logic                  auto_poll,
	output txsac_pkg::txsac_evt_t      evt
);
	// one-cycle event pulses from bench requests: jabber, missing, done, poll
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt <= '0;
		end else begin
			// jabber only from a running engine
			evt.jabber_expired <= req[3] & ctl.fetch_en;
			evt.desc_missing <= req[2] & ctl.fetch_en;
			// done and first descriptor ic request registered separately, unqualified
			evt.frame_done <= req[1];
			evt.first_desc_ic <= req_ic;
			// poll demand after ownership handed back
			evt.poll_demand <= req[0];
			evt.auto_poll_en <= auto_poll;
		end
	end
endmodule

// >>> tb/txsac_top_tb.sv
// self-checking bench for the tx status and access control block
`timescale 1ns/1ps

module txsac_top_tb;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, irq, speed_100, whole, req_ic, auto_poll;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic [3:0] req;
	logic [11:0] fifo_bytes;
	txsac_pkg::txsac_evt_t evt;
	txsac_pkg::txsac_ctl_t ctl;
	int fail_count, n_checks, cyc;
	logic [11:0] thr_tab [0:7] = '{12'h080, 12'h100, 12'h200, 12'h400,
		12'h048, 12'h060, 12'h080, 12'h0A0};

	txsac_top txsac_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .evt(evt), .speed_100(speed_100), .fifo_bytes(fifo_bytes),
		.fifo_frame_whole(whole), .ctl(ctl), .irq(irq));
	txsac_engine_model txsac_engine_model_inst (.aclk(aclk), .aresetn(aresetn),
		.ctl(ctl), .req(req), .req_ic(req_ic), .auto_poll(auto_poll), .evt(evt));

	// clock and cycle ceiling
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask

	// axi4-lite write: address and data offered together, response awaited
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awvalid && awready) begin aw_ok = 1'b1; awvalid <= 1'b0; end
			if (wvalid && wready) begin w_ok = 1'b1; wvalid <= 1'b0; end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		rs = bresp;
		bready <= 1'b0;
	endtask

	// axi4-lite read
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask

	task automatic w(input logic [7:0] a, input logic [31:0] v);
		wr(a, v, r);
	endtask

	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		rd(a, d, r);
		chk(n, d, e);
	endtask

	// one-cycle event request to the engine model, then let flags land
	task automatic ev(input logic [3:0] q, input logic ic);
		@(posedge aclk);
		req <= q; req_ic <= ic;
		@(posedge aclk);
		req <= 4'h0; req_ic <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask

	initial begin
		aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
		rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; req = 4'h0;
		req_ic = 1'b0; speed_100 = 1'b1; fifo_bytes = 12'h000; whole = 1'b0;
		auto_poll = 1'b0;
		fail_count = 0; n_checks = 0; cyc = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rchk("nar reset", 8'h30, 32'h00080000);
		chk("sqe test off", {31'h0, ctl.sqe_test_en}, 32'h0);
		rchk("stopped flag", 8'h28, 32'h00000002);
		w(8'h28, 32'h0000000F);
		rchk("stopped resets", 8'h28, 32'h00000002);
		wr(8'h04, 32'h0000FFFF, r);
		chk("unmapped wr", {30'h0, r}, 32'h2);
		rd(8'h04, d, r);
		chk("unmapped rd", {30'h0, r, d[1:0]}, 32'h8);
		w(8'h38, 32'h0000000F);
		@(posedge aclk);
		chk("irq stopped", {31'h0, irq}, 32'h1);
		$display("test reset and access done");
		w(8'h30, 32'h00082000);
		rchk("run state", 8'h3C, 32'h00000002);
		chk("fetch on", {31'h0, ctl.fetch_en}, 32'h1);
		w(8'h28, 32'h0000000F);
		rchk("flags clear", 8'h28, 32'h0);
		chk("irq low", {31'h0, irq}, 32'h0);
		ev(4'h2, 1'b0);
		rchk("done no ic", 8'h28, 32'h0);
		ev(4'h2, 1'b1);
		rchk("done ic", 8'h28, 32'h00000001);
		chk("irq done", {31'h0, irq}, 32'h1);
		w(8'h28, 32'h0);
		rchk("write zero keeps", 8'h28, 32'h00000001);
		w(8'h38, 32'h0000000E);
		@(posedge aclk);
		chk("irq masked", {31'h0, irq}, 32'h0);
		w(8'h28, 32'h00000001);
		rchk("write one clears", 8'h28, 32'h0);
		$display("test status flags done");
		ev(4'h4, 1'b0);
		rchk("desc missing", 8'h28, 32'h00000004);
		rchk("suspended", 8'h3C, 32'h00000006);
		ev(4'h1, 1'b0);
		rchk("resumed", 8'h3C, 32'h00000002);
		w(8'h28, 32'h0000000F);
		auto_poll <= 1'b1;
		ev(4'h4, 1'b0);
		rchk("auto resume", 8'h3C, 32'h00000002);
		rchk("auto desc missing", 8'h28, 32'h00000004);
		auto_poll <= 1'b0;
		w(8'h28, 32'h0000000F);
		ev(4'h8, 1'b0);
		rchk("jabber flags", 8'h28, 32'h0000000A);
		rchk("jabber stop", 8'h3C, 32'h0);
		chk("desc jabber", {31'h0, ctl.jabber_flag_in_desc}, 32'h1);
		$display("test suspend and jabber done");
		for (int i = 0; i < 8; i++) begin
			speed_100 <= (i < 4);
			w(8'h30, 32'(i % 4) << 14);
			chk("threshold", {20'h0, ctl.threshold_bytes}, {20'h0, thr_tab[i]});
		end
		chk("sqe test on", {31'h0, ctl.sqe_test_en}, 32'h1);
		speed_100 <= 1'b1;
		fifo_bytes <= 12'h07F;
		w(8'h30, 32'h00002000);
		chk("desc jabber clr", {31'h0, ctl.jabber_flag_in_desc}, 32'h0);
		chk("below thr", {31'h0, ctl.start_tx}, 32'h0);
		fifo_bytes <= 12'h080;
		repeat (2) @(posedge aclk);
		chk("at thr", {31'h0, ctl.start_tx}, 32'h1);
		w(8'h30, 32'h0);
		rchk("run zero stops", 8'h3C, 32'h0);
		chk("fetch off", {31'h0, ctl.fetch_en}, 32'h0);
		fifo_bytes <= 12'h400;
		w(8'h30, 32'h00200000);
		w(8'h30, 32'h00202000);
		chk("sf partial", {31'h0, ctl.start_tx}, 32'h0);
		whole <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("sf whole", {31'h0, ctl.start_tx}, 32'h1);
		w(8'h30, 32'h0);
		$display("test controls done");
		print_verdict();
	end
endmodule
